// >>> src/scan_cfg_pkg.sv
package scan_cfg_pkg;
  localparam int          WORD_W        = 16;
  localparam int          SEL_HI        = 15;
  localparam int          SEL_LO        = 11;
  localparam int          FIELD_HI      = 10;
  localparam int          FIELD_LO      = 3;
  localparam int          FIELD_W       = 8;
  localparam logic        CFG_WORD_FLAG = 1'h1;
  localparam logic [4:0]  UNIPOLAR_CODE = 5'h11;
  localparam logic [4:0]  POLARITY_CODE = 5'h12;
  localparam logic [4:0]  UPPER_CODE    = 5'h14;
  localparam logic [4:0]  LOWER_CODE    = 5'h15;
  localparam logic [4:0]  SEQ_CODE      = 5'h16;
  localparam logic [7:0]  FIELD_RESET   = 8'h00;
  localparam logic [4:0]  CNT_RESET     = 5'h00;
  localparam int          CNT_W         = 5;
  localparam int          SEQ_MAX       = 256;
endpackage

// >>> src/cfg_word_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cfg_word_if;
  logic        valid;
  logic [15:0] word;
  modport src (output valid, output word);
  modport dst (input valid, input word);
endinterface
`default_nettype wire

// >>> src/serial_word_rx.sv
`timescale 1ns/100ps
`default_nettype none
module serial_word_rx (
  input  wire logic clk,
  input  wire logic resetn,
  // serial pins
  input  wire logic sclk_pin,
  input  wire logic csn_pin,
  input  wire logic din_pin,
  // assembled word
  cfg_word_if.src   out
);
  logic [2:0]  sclk_s_r, sclk_s_nxt;
  logic [1:0]  csn_s_r, csn_s_nxt, din_s_r, din_s_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic        vld_r, vld_nxt;
  logic [15:0] word_r, word_nxt;
  logic        rise;

  always_comb begin
    sclk_s_nxt = {sclk_s_r[1:0], sclk_pin};
    csn_s_nxt  = {csn_s_r[0], csn_pin};
    din_s_nxt  = {din_s_r[0], din_pin};
    // edge taken from second and third stages only
    rise       = sclk_s_r[1] & ~sclk_s_r[2];
    sh_nxt     = sh_r;
    cnt_nxt    = cnt_r;
    vld_nxt    = 1'b0;
    word_nxt   = word_r;
    if (csn_s_r[1]) begin
      cnt_nxt = scan_cfg_pkg::CNT_RESET;
    end else if (rise && cnt_r < 5'h10) begin
      sh_nxt  = {sh_r[14:0], din_s_r[1]};
      cnt_nxt = cnt_r + 5'h01;
      if (cnt_r == 5'h0F) begin
        vld_nxt  = 1'b1;
        word_nxt = {sh_r[14:0], din_s_r[1]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_s_r <= 3'h0;
      csn_s_r  <= 2'h3;
      din_s_r  <= 2'h0;
      sh_r     <= 16'h0000;
      cnt_r    <= 5'h00;
      vld_r    <= 1'b0;
      word_r   <= 16'h0000;
    end else begin
      sclk_s_r <= sclk_s_nxt;
      csn_s_r  <= csn_s_nxt;
      din_s_r  <= din_s_nxt;
      sh_r     <= sh_nxt;
      cnt_r    <= cnt_nxt;
      vld_r    <= vld_nxt;
      word_r   <= word_nxt;
    end
  end

  assign out.valid = vld_r;
  assign out.word  = word_r;
endmodule
`default_nettype wire

// >>> src/channel_scan_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module channel_scan_config_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // serial interface pins
  input  wire logic        sclk_pin,
  input  wire logic        csn_pin,
  input  wire logic        din_pin,
  // unipolar pair setting from the neighbouring register
  input  wire logic [7:0]  pair_pseudo_diff,
  // conversion engine status
  input  wire logic        seq_busy,
  // configuration outputs
  output logic [7:0]       pair_bipolar,
  output logic [7:0]       pair_bipolar_eff,
  output logic [15:0]      scan_include,
  output logic [8:0]       seq_conversions,
  // mode-control path
  output logic             mode_word_valid,
  output logic [15:0]      mode_word,
  output logic             result_valid
);
  cfg_word_if w ();

  serial_word_rx u_rx (
    .clk      (clk),
    .resetn   (resetn),
    .sclk_pin (sclk_pin),
    .csn_pin  (csn_pin),
    .din_pin  (din_pin),
    .out      (w)
  );

  function automatic logic sel_hit(input logic [15:0] wd,
                                   input logic [4:0]  code);
    sel_hit = wd[15] == scan_cfg_pkg::CFG_WORD_FLAG &&
              wd[scan_cfg_pkg::SEL_HI:scan_cfg_pkg::SEL_LO] == code;
  endfunction

  logic [7:0]  pol_r, pol_nxt, up_r, up_nxt, lo_r, lo_nxt, seq_r, seq_nxt;
  logic        rv_r, rv_nxt, mv_r, mv_nxt;
  logic [15:0] mw_r, mw_nxt;
  logic [7:0]  fld;
  logic        is_cfg;

  always_comb begin
    // bits 2..0 of a config word are never looked at
    fld     = w.word[scan_cfg_pkg::FIELD_HI:scan_cfg_pkg::FIELD_LO];
    is_cfg  = w.word[15] == scan_cfg_pkg::CFG_WORD_FLAG;
    pol_nxt = pol_r;
    up_nxt  = up_r;
    lo_nxt  = lo_r;
    seq_nxt = seq_r;
    rv_nxt  = rv_r;
    mv_nxt  = 1'b0;
    mw_nxt  = mw_r;
    if (w.valid) begin
      if (sel_hit(w.word, scan_cfg_pkg::POLARITY_CODE))
        pol_nxt = fld;
      if (sel_hit(w.word, scan_cfg_pkg::UPPER_CODE))
        up_nxt = fld;
      if (sel_hit(w.word, scan_cfg_pkg::LOWER_CODE))
        lo_nxt = fld;
      if (sel_hit(w.word, scan_cfg_pkg::SEQ_CODE))
        seq_nxt = fld;
      if (is_cfg) begin
        // engine keeps its current mode; a write while seq_busy makes results stale until new mode word
        if (seq_busy)
          rv_nxt = 1'b0;
      end else begin
        mv_nxt = 1'b1;
        mw_nxt = w.word;
        rv_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pol_r <= scan_cfg_pkg::FIELD_RESET;
      up_r  <= scan_cfg_pkg::FIELD_RESET;
      lo_r  <= scan_cfg_pkg::FIELD_RESET;
      seq_r <= scan_cfg_pkg::FIELD_RESET;
      rv_r  <= 1'b0;
      mv_r  <= 1'b0;
      mw_r  <= 16'h0000;
    end else begin
      pol_r <= pol_nxt;
      up_r  <= up_nxt;
      lo_r  <= lo_nxt;
      seq_r <= seq_nxt;
      rv_r  <= rv_nxt;
      mv_r  <= mv_nxt;
      mw_r  <= mw_nxt;
    end
  end

  // bit 10 is pair 0/1, so reverse into pair-indexed order
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_map
      assign pair_bipolar[i]     = pol_r[7-i];
      assign pair_bipolar_eff[i] = pol_r[7-i] & ~pair_pseudo_diff[i];
      assign scan_include[15-i]  = up_r[7-i];
      assign scan_include[7-i]   = lo_r[7-i];
    end
  endgenerate

  // 9-bit result: an 8-bit field plus one tops out at 256
  assign seq_conversions = {1'b0, seq_r} + 9'h001;
  assign mode_word_valid = mv_r;
  assign mode_word       = mw_r;
  assign result_valid    = rv_r;

  // assertion helper: a config write seen while a sequence ran, kept until
  // the next mode word; only the checks below read it
  logic stale_r, stale_nxt;

  always_comb begin
    stale_nxt = stale_r;
    if (w.valid && is_cfg && seq_busy)
      stale_nxt = 1'b1;
    else if (w.valid && !is_cfg)
      stale_nxt = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!resetn)
      stale_r <= 1'b0;
    else
      stale_r <= stale_nxt;
  end

  a_seq_cap: assert property (
    @(posedge clk) disable iff (!resetn)
    seq_conversions != 9'h000 && seq_conversions <= 9'h100)
    else $error("sequence length out of range");

  a_pol_load: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::POLARITY_CODE)
    |=> pol_r == $past(w.word[10:3]))
    else $error("polarity register not loaded");

  a_up_load: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::UPPER_CODE)
    |=> scan_include[15:8] == $past(w.word[10:3]))
    else $error("upper mask not loaded");

  a_lo_load: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::LOWER_CODE)
    |=> scan_include[7:0] == $past(w.word[10:3]))
    else $error("lower mask not loaded");

  a_seq_load: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::SEQ_CODE)
    |=> seq_conversions == {1'b0, $past(w.word[10:3])} + 9'h001)
    else $error("sequence length not loaded");

  a_hold_regs: assert property (
    @(posedge clk) disable iff (!resetn)
    !w.valid
    |=> $stable(pol_r) && $stable(scan_include) && $stable(seq_r))
    else $error("register changed without write");

  a_uni_wins: assert property (
    @(posedge clk) disable iff (!resetn)
    (pair_bipolar_eff & pair_pseudo_diff) == 8'h00)
    else $error("unipolar precedence lost");

  a_bip_stands: assert property (
    @(posedge clk) disable iff (!resetn)
    pair_pseudo_diff == 8'h00 |-> pair_bipolar_eff == pair_bipolar)
    else $error("bipolar setting lost without unipolar pair");

  a_cfg_invalid: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && w.word[15] && seq_busy
    |=> !result_valid [*1] ##1 (!result_valid || mode_word_valid))
    else $error("result valid after busy config write");

  a_mode_pass: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && !w.word[15]
    |=> mode_word_valid && result_valid)
    else $error("mode word not forwarded");

  a_pol_reset: assert property (
    @(posedge clk)
    !resetn |=> pair_bipolar == 8'h00)
    else $error("polarity bits not cleared by reset");

  a_up_reset: assert property (
    @(posedge clk)
    !resetn |=> scan_include[15:8] == 8'h00)
    else $error("upper mask not cleared by reset");

  a_lo_reset: assert property (
    @(posedge clk)
    !resetn |=> scan_include[7:0] == 8'h00)
    else $error("lower mask not cleared by reset");

  a_seq_reset: assert property (
    @(posedge clk)
    !resetn |=> seq_conversions == 9'h001)
    else $error("sequence length not one after reset");

  a_pair_order: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::POLARITY_CODE)
    |=> pair_bipolar[0] == $past(w.word[10]) &&
        pair_bipolar[7] == $past(w.word[3]))
    else $error("pair order of polarity bits wrong");

  a_ch15_order: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::UPPER_CODE)
    |=> scan_include[15] == $past(w.word[10]) &&
        scan_include[8] == $past(w.word[3]))
    else $error("channel order of upper mask wrong");

  a_ch7_order: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::LOWER_CODE)
    |=> scan_include[7] == $past(w.word[10]) &&
        scan_include[0] == $past(w.word[3]))
    else $error("channel order of lower mask wrong");

  a_seq_top: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::SEQ_CODE) &&
    w.word[10:3] == 8'hFF
    |=> seq_conversions == 9'h100)
    else $error("full length field not 256 conversions");

  a_seq_floor: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::SEQ_CODE) &&
    w.word[10:3] == 8'h00
    |=> seq_conversions == 9'h001)
    else $error("empty length field not one conversion");

  a_low_bits: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && sel_hit(w.word, scan_cfg_pkg::POLARITY_CODE) &&
    w.word[2:0] != 3'h0
    |=> pol_r == $past(w.word[10:3]))
    else $error("low bits disturbed a register");

  a_refuse_code: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && !sel_hit(w.word, scan_cfg_pkg::POLARITY_CODE) &&
    !sel_hit(w.word, scan_cfg_pkg::UPPER_CODE) &&
    !sel_hit(w.word, scan_cfg_pkg::LOWER_CODE) &&
    !sel_hit(w.word, scan_cfg_pkg::SEQ_CODE)
    |=> $stable(pol_r) && $stable(scan_include) && $stable(seq_r))
    else $error("register loaded by a foreign word");

  a_mode_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    !w.valid |=> !mode_word_valid && $stable(mode_word))
    else $error("mode path changed without a word");

  a_cfg_no_mode: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && w.word[15]
    |=> !mode_word_valid && $stable(mode_word))
    else $error("config word leaked to mode path");

  a_mode_word: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && !w.word[15] |=> mode_word == $past(w.word))
    else $error("mode word not captured");

  a_idle_keep: assert property (
    @(posedge clk) disable iff (!resetn)
    w.valid && w.word[15] && !seq_busy |=> $stable(result_valid))
    else $error("result valid moved on idle config write");

  a_stale_result: assert property (
    @(posedge clk) disable iff (!resetn)
    stale_r |-> !result_valid)
    else $error("result valid before new mode word");

  a_valid_rise: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(result_valid) |-> mode_word_valid)
    else $error("result valid rose without mode word");

  a_valid_pulse: assert property (
    @(posedge clk) disable iff (!resetn)
    mode_word_valid |=> !mode_word_valid)
    else $error("mode strobe longer than one cycle");
endmodule
`default_nettype wire

// >>> verification/host_serial.sv
`timescale 1ns/100ps
`default_nettype none
module host_serial (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      csn,
  output logic      din
);
  initial begin
    sclk = 1'b0;
    csn  = 1'b1;
    din  = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // msb first; each phase lasts 3 clocks so the pin synchronisers see it
  task automatic send(input logic [15:0] w, input int n);
    csn = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = w[15-i];
      gap(3);
      sclk = 1'b1;
      gap(3);
      sclk = 1'b0;
    end
    gap(3);
    csn = 1'b1;
    // no pull on the data line, so show the inverse once released
    din = ~din;
    gap(4);
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk, resetn, seq_busy, sclk, csn, din;
  logic        mode_word_valid, result_valid, rv;
  logic [7:0]  pair_pseudo_diff, pair_bipolar, pair_bipolar_eff;
  logic [7:0]  pol, up, lo, sq, r;
  logic [15:0] scan_include, mode_word, mw, w;
  logic [8:0]  seq_conversions;
  logic [31:0] f;
  int          fail_count, tests_run, seed, pulses, exp_pulses, k, nb;
  logic [4:0]  codes [7] = '{5'h12, 5'h14, 5'h15, 5'h16, 5'h11, 5'h13, 5'h00};

  channel_scan_config_regs uut (.clk(clk), .resetn(resetn),
    .sclk_pin(sclk), .csn_pin(csn), .din_pin(din),
    .pair_pseudo_diff(pair_pseudo_diff), .seq_busy(seq_busy),
    .pair_bipolar(pair_bipolar), .pair_bipolar_eff(pair_bipolar_eff),
    .scan_include(scan_include), .seq_conversions(seq_conversions),
    .mode_word_valid(mode_word_valid), .mode_word(mode_word),
    .result_valid(result_valid));
  host_serial host (.clk(clk), .sclk(sclk), .csn(csn), .din(din));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (mode_word_valid === 1'b1) pulses++;
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    results;
  end

  task automatic results;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check_all;
    r = {<<{pol}};
    chk({8'h00, pair_bipolar}, {8'h00, r});
    chk({8'h00, pair_bipolar_eff}, {8'h00, r & ~pair_pseudo_diff});
    chk(scan_include, {up, lo});
    chk({7'h00, seq_conversions}, 16'(sq) + 16'h0001);
    chk({15'h0000, result_valid}, {15'h0000, rv});
    chk(16'(pulses), 16'(exp_pulses));
    chk(mode_word, mw);
  endtask
  task automatic do_reset;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    {pol, up, lo, sq, rv, mw} = '0;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    seed = 19623;
    {fail_count, tests_run, pulses, exp_pulses} = '0;
    seq_busy = 1'b0;
    pair_pseudo_diff = 8'h00;
    do_reset;
    check_all;
    for (int n = 0; n < 40; n++) begin
      f = $random(seed);
      k = (n < 2) ? 3 : int'($unsigned(f[15:0]) % 7);
      w = (k == 6) ? {1'b0, f[14:0]} : {codes[k], f[10:0]};
      // both ends of the length field: 1 and 256 conversions
      if (n < 2) w[10:3] = (n == 0) ? 8'hFF : 8'h00;
      nb = (n % 9 == 8) ? 10 : 16;
      // partial frames are dropped, so keep busy clear around them
      seq_busy = (k < 6 && nb == 16) ? f[20] : 1'b0;
      pair_pseudo_diff = f[31:24];
      host.send(w, nb);
      if (nb == 16) begin
        case (k)
          0: pol = w[10:3];
          1: up = w[10:3];
          2: lo = w[10:3];
          3: sq = w[10:3];
          6: begin
            mw = w;
            rv = 1'b1;
            exp_pulses++;
          end
          default: ;
        endcase
        if (k < 6 && seq_busy) rv = 1'b0;
      end
      check_all;
    end
    do_reset;
    check_all;
    results;
  end
endmodule
`default_nettype wire
